// ### rtl/fsru_host.sv
// Host controller that polls flash status, pulses hardware reset and runs temporary unprotect.
`default_nettype none
module fsru_host (
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire logic poll_start_i,
   input wire logic [1:0] poll_mode_i,
   input wire logic [fsru_pkg::ADDR_W-1:0] poll_addr_i,
   input wire logic expect_bit_i,
   input wire logic reset_start_i,
   input wire logic unprot_start_i,
   input wire logic unprot_end_i,
   output logic busy_o,
   output logic done_o,
   output logic [1:0] result_o,
   output logic unprot_ready_o,
   output logic [fsru_pkg::DATA_W-1:0] last_status_o,
   output logic [fsru_pkg::ADDR_W-1:0] flash_addr_o,
   output logic flash_ce_n_o,
   output logic flash_oe_n_o,
   output logic flash_we_n_o,
   output logic flash_reset_n_o,
   output logic flash_hv_en_o,
   output logic flash_dq_oe_o,
   output logic [fsru_pkg::DATA_W-1:0] flash_dq_o,
   input wire logic [fsru_pkg::DATA_W-1:0] flash_dq_i,
   input wire logic ready_busy_out_i
);
   fsru_pkg::fsru_state_t state_q, state_d;
   fsru_pkg::fsru_mode_t mode_q, mode_d;
   logic [fsru_pkg::CNT_W-1:0] cnt_q, cnt_d;
   logic [fsru_pkg::ADDR_W-1:0] addr_q, addr_d;
   logic [fsru_pkg::DATA_W-1:0] rd1_q, rd1_d, rd2_q, rd2_d;
   logic expect_q, expect_d, tl_seen_q, tl_seen_d, was_busy_q, was_busy_d;
   logic oe_n_q, oe_n_d, rst_n_q, rst_n_d, hv_q, hv_d;
   logic done_q, done_d, unprot_rdy_q, unprot_rdy_d;
   logic [1:0] result_q, result_d;
   logic [fsru_pkg::DATA_W:0] pins_sync;
   logic [fsru_pkg::DATA_W-1:0] dq_sync;
   logic rb_sync;

   // =====================================================================
   // Pin inputs pass two flip-flops before use.
   fsru_sync #(.W(fsru_pkg::DATA_W + 1)) u_sync (
      .ref_clk_i(ref_clk_i),
      .srst_i(srst_i),
      .async_i({ready_busy_out_i, flash_dq_i}),
      .sync_o(pins_sync)
   );
   assign dq_sync = pins_sync[fsru_pkg::DATA_W-1:0];
   assign rb_sync = pins_sync[fsru_pkg::DATA_W];

   // Selects the toggle bit that matches the poll method.
   function automatic logic tog_bit(input fsru_pkg::fsru_mode_t m, input logic [fsru_pkg::DATA_W-1:0] d);
      tog_bit = (m == fsru_pkg::MODE_SECTOR) ? d[fsru_pkg::SECTOR_TOGGLE_POS] : d[fsru_pkg::TOGGLE_POS];
   endfunction

   // =====================================================================
   // Next-state logic for the poll, reset and unprotect sequences.
   always_comb begin
      state_d = state_q;
      mode_d = mode_q;
      cnt_d = cnt_q;
      addr_d = addr_q;
      rd1_d = rd1_q;
      rd2_d = rd2_q;
      expect_d = expect_q;
      tl_seen_d = tl_seen_q;
      was_busy_d = was_busy_q;
      oe_n_d = oe_n_q;
      rst_n_d = rst_n_q;
      hv_d = hv_q;
      done_d = 1'b0;
      result_d = result_q;
      unprot_rdy_d = unprot_rdy_q;
      case (state_q)
         fsru_pkg::ST_IDLE: begin
            if (reset_start_i) begin
               was_busy_d = ~rb_sync; // Busy device needs the long recovery.
               rst_n_d = 1'b0;
               cnt_d = fsru_pkg::CNT_W'(fsru_pkg::RESET_LOW_CYC);
               state_d = fsru_pkg::ST_RST_LOW;
            end else if (unprot_start_i) begin
               hv_d = 1'b1; // Device unprotects all sectors while held.
               cnt_d = fsru_pkg::CNT_W'(fsru_pkg::UNPROT_SETUP_CYC);
               state_d = fsru_pkg::ST_UNPROT;
            end else if (poll_start_i) begin
               mode_d = fsru_pkg::fsru_mode_t'(poll_mode_i);
               addr_d = poll_addr_i; // Data polling uses the valid status address.
               expect_d = expect_bit_i;
               tl_seen_d = 1'b0;
               oe_n_d = 1'b0;
               cnt_d = fsru_pkg::CNT_W'(fsru_pkg::READ_PULSE_CYC);
               state_d = fsru_pkg::ST_RD1;
            end
         end
         fsru_pkg::ST_RD1, fsru_pkg::ST_RD2: begin
            if (cnt_q != '0) begin
               cnt_d = cnt_q - 1'b1;
            end else if (!oe_n_q) begin
               oe_n_d = 1'b1; // Each read is a separate strobe so toggles advance.
               if (state_q == fsru_pkg::ST_RD1) begin
                  rd1_d = dq_sync;
               end else begin
                  rd2_d = dq_sync;
               end
               cnt_d = fsru_pkg::CNT_W'(fsru_pkg::READ_PULSE_CYC);
            end else if (state_q == fsru_pkg::ST_RD1 && mode_q != fsru_pkg::MODE_DATA_POLL) begin
               oe_n_d = 1'b0; // Second consecutive read for the toggle comparison.
               cnt_d = fsru_pkg::CNT_W'(fsru_pkg::READ_PULSE_CYC);
               state_d = fsru_pkg::ST_RD2;
            end else begin
               state_d = fsru_pkg::ST_JUDGE;
            end
         end
         fsru_pkg::ST_JUDGE: begin
            if (mode_q == fsru_pkg::MODE_DATA_POLL) begin
               if (rd1_q[fsru_pkg::DATA_POLL_POS] == expect_q) begin
                  result_d = fsru_pkg::RES_DONE; // True data replaced the complement.
                  state_d = fsru_pkg::ST_RECHK;
               end else if (tl_seen_q) begin
                  result_d = fsru_pkg::RES_FAIL;
                  state_d = fsru_pkg::ST_RECHK;
               end else if (rd1_q[fsru_pkg::TIME_LIMIT_POS]) begin
                  tl_seen_d = 1'b1; // Read data-poll once more before failing.
                  oe_n_d = 1'b0;
                  cnt_d = fsru_pkg::CNT_W'(fsru_pkg::READ_PULSE_CYC);
                  state_d = fsru_pkg::ST_RD1;
               end else begin
                  oe_n_d = 1'b0;
                  cnt_d = fsru_pkg::CNT_W'(fsru_pkg::READ_PULSE_CYC);
                  state_d = fsru_pkg::ST_RD1;
               end
            end else begin
               if (tog_bit(mode_q, rd1_q) == tog_bit(mode_q, rd2_q)) begin
                  result_d = fsru_pkg::RES_DONE; // Not toggling means finished or not suspended.
                  state_d = fsru_pkg::ST_RECHK;
               end else if (tl_seen_q) begin
                  result_d = fsru_pkg::RES_FAIL;
                  state_d = fsru_pkg::ST_RECHK;
               end else begin
                  tl_seen_d = rd2_q[fsru_pkg::TIME_LIMIT_POS]; // Check toggling again after time limit.
                  oe_n_d = 1'b0;
                  cnt_d = fsru_pkg::CNT_W'(fsru_pkg::READ_PULSE_CYC);
                  state_d = fsru_pkg::ST_RD1;
               end
            end
         end
         fsru_pkg::ST_RECHK: begin
            done_d = 1'b1;
            state_d = fsru_pkg::ST_IDLE;
         end
         fsru_pkg::ST_RST_LOW: begin
            if (cnt_q != '0) begin
               cnt_d = cnt_q - 1'b1;
            end else begin
               rst_n_d = 1'b1; // Held low for the minimum pulse.
               cnt_d = was_busy_q ? fsru_pkg::CNT_W'(fsru_pkg::READY_WAIT_CYC) :
                  fsru_pkg::CNT_W'(fsru_pkg::RESET_HIGH_CYC); // Recovery before access.
               state_d = fsru_pkg::ST_RST_HIGH;
            end
         end
         fsru_pkg::ST_RST_HIGH: begin
            if (cnt_q != '0) begin
               cnt_d = cnt_q - 1'b1;
            end else begin
               result_d = fsru_pkg::RES_RESET;
               state_d = fsru_pkg::ST_RECHK;
            end
         end
         fsru_pkg::ST_UNPROT: begin
            if (cnt_q != '0) begin
               cnt_d = cnt_q - 1'b1;
            end else begin
               unprot_rdy_d = 1'b1; // Setup time at high voltage has passed.
               result_d = fsru_pkg::RES_UNPROT;
               done_d = 1'b1;
               state_d = fsru_pkg::ST_UNPROT_HOLD;
            end
         end
         fsru_pkg::ST_UNPROT_HOLD: begin
            if (unprot_end_i) begin
               hv_d = 1'b0; // Device restores protection on return.
               unprot_rdy_d = 1'b0;
               cnt_d = fsru_pkg::CNT_W'(fsru_pkg::RESET_HIGH_CYC);
               state_d = fsru_pkg::ST_RST_HIGH;
            end
         end
         default: begin
            state_d = fsru_pkg::ST_IDLE;
         end
      endcase
   end

   // Registers for the sequencer.
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         state_q <= fsru_pkg::ST_IDLE;
         mode_q <= fsru_pkg::MODE_DATA_POLL;
         cnt_q <= '0;
         addr_q <= '0;
         rd1_q <= '0;
         rd2_q <= '0;
         expect_q <= 1'b0;
         tl_seen_q <= 1'b0;
         was_busy_q <= 1'b0;
         oe_n_q <= 1'b1;
         rst_n_q <= 1'b1;
         hv_q <= 1'b0;
         done_q <= 1'b0;
         result_q <= fsru_pkg::RES_DONE;
         unprot_rdy_q <= 1'b0;
      end else begin
         state_q <= state_d;
         mode_q <= mode_d;
         cnt_q <= cnt_d;
         addr_q <= addr_d;
         rd1_q <= rd1_d;
         rd2_q <= rd2_d;
         expect_q <= expect_d;
         tl_seen_q <= tl_seen_d;
         was_busy_q <= was_busy_d;
         oe_n_q <= oe_n_d;
         rst_n_q <= rst_n_d;
         hv_q <= hv_d;
         done_q <= done_d;
         result_q <= result_d;
         unprot_rdy_q <= unprot_rdy_d;
      end
   end

   // =====================================================================
   // Outputs: pins come from flip-flops or constants; the bus is never driven for status reads.
   assign busy_o = (state_q != fsru_pkg::ST_IDLE) && (state_q != fsru_pkg::ST_UNPROT_HOLD);
   assign done_o = done_q;
   assign result_o = result_q;
   assign unprot_ready_o = unprot_rdy_q;
   assign last_status_o = (mode_q == fsru_pkg::MODE_DATA_POLL) ? rd1_q : rd2_q;
   assign flash_addr_o = addr_q;
   assign flash_ce_n_o = oe_n_q;
   assign flash_oe_n_o = oe_n_q;
   assign flash_we_n_o = 1'b1;
   assign flash_reset_n_o = rst_n_q;
   assign flash_hv_en_o = hv_q;
   assign flash_dq_oe_o = 1'b0;
   assign flash_dq_o = '0;
endmodule
`default_nettype wire

// ### rtl/fsru_pkg.sv
// Package of constants and types for the flash status, reset and unprotect host controller.
`default_nettype none
package fsru_pkg;
   // =====================================================================
   // Timing figures and derived cycle counts at 250 MHz.
   localparam int CLK_PERIOD_NS = 4;
   localparam int RESET_LOW_NS = 500;
   localparam int RESET_HIGH_NS = 50;
   localparam int UNPROT_SETUP_US = 4;
   localparam int READY_BUSY_US = 20;
   localparam int READ_PULSE_NS = 100;
   localparam int RESET_LOW_CYC = (RESET_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RESET_HIGH_CYC = (RESET_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int UNPROT_SETUP_CYC = (UNPROT_SETUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int READY_WAIT_CYC = (READY_BUSY_US * 1000) / CLK_PERIOD_NS;
   localparam int READ_PULSE_CYC = (READ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // =====================================================================
   // Widths and status bit positions.
   localparam int ADDR_W = 18;
   localparam int DATA_W = 16;
   localparam int CNT_W = 16;
   localparam int DATA_POLL_POS = 7;
   localparam int TOGGLE_POS = 6;
   localparam int TIME_LIMIT_POS = 5;
   localparam int SECTOR_TOGGLE_POS = 2;
   // =====================================================================
   // Controller states, Gray coded along the poll path.
   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_RD1 = 4'h1,
      ST_RD2 = 4'h3,
      ST_JUDGE = 4'h2,
      ST_RECHK = 4'h6,
      ST_RST_LOW = 4'h7,
      ST_RST_HIGH = 4'h5,
      ST_UNPROT = 4'h4,
      ST_UNPROT_HOLD = 4'hc
   } fsru_state_t;
   // Poll methods.
   typedef enum logic [1:0] {
      MODE_DATA_POLL = 2'h0,
      MODE_TOGGLE = 2'h1,
      MODE_SECTOR = 2'h2
   } fsru_mode_t;
   // Outcomes.
   typedef enum logic [1:0] {
      RES_DONE = 2'h0,
      RES_FAIL = 2'h1,
      RES_RESET = 2'h2,
      RES_UNPROT = 2'h3
   } fsru_result_t;
endpackage
`default_nettype wire

// ### rtl/fsru_sync.sv
// Two-flip-flop synchroniser for pin inputs, with parameterised width.
`default_nettype none
module fsru_sync #(
   parameter int W = 1
) (
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);
   logic [W-1:0] meta_q;
   logic [W-1:0] meta_d;
   logic [W-1:0] sync_q;
   logic [W-1:0] sync_d;

   // =====================================================================
   // The first stage is read only by the second stage.
   always_comb begin
      meta_d = async_i;
      sync_d = meta_q;
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign sync_o = sync_q;
endmodule
`default_nettype wire

// ### sim/fsru_host_chk.sv
// Checker of pin timing and poll outcomes of the flash host controller.
`default_nettype none
module fsru_host_chk (
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire logic poll_start_i,
   input wire logic [1:0] poll_mode_i,
   input wire logic [fsru_pkg::ADDR_W-1:0] poll_addr_i,
   input wire logic busy_o,
   input wire logic done_o,
   input wire logic [1:0] result_o,
   input wire logic unprot_ready_o,
   input wire logic [fsru_pkg::ADDR_W-1:0] flash_addr_o,
   input wire logic flash_oe_n_o,
   input wire logic flash_reset_n_o,
   input wire logic flash_hv_en_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========
   // Helper counters.
   logic [11:0] low_q, low_d, hv_q, hv_d;
   logic [7:0] hi_q, hi_d;
   logic [3:0] rd_q, rd_d;
   logic [1:0] mode_q, mode_d;
   logic [fsru_pkg::ADDR_W-1:0] addr_q, addr_d;
   logic oe_q, take;
   // Counts reset-low, reset-high and high-voltage cycles, and the reads of the current poll.
   always_comb begin
      take = poll_start_i && !busy_o && !flash_hv_en_o;
      low_d = flash_reset_n_o ? 12'h000 : low_q + 12'h001;
      hi_d = !flash_reset_n_o ? 8'h00 : hi_q + {7'h00, hi_q != 8'hff};
      hv_d = flash_hv_en_o ? hv_q + 12'h001 : 12'h000;
      rd_d = take ? 4'h0 : rd_q + {3'h0, oe_q && !flash_oe_n_o && rd_q != 4'hf};
      mode_d = take ? poll_mode_i : mode_q;
      addr_d = take ? poll_addr_i : addr_q;
   end
   // Registers the helper state; the reset-high count starts saturated.
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         {low_q, hi_q, hv_q, rd_q, mode_q, addr_q, oe_q} <= {12'h000, 8'hff, 12'h000, 4'h0, 2'h0, 18'h00000, 1'b1};
      end else begin
         {low_q, hi_q, hv_q, rd_q, mode_q, addr_q, oe_q} <= {low_d, hi_d, hv_d, rd_d, mode_d, addr_d, flash_oe_n_o};
      end
   end
   // ==========
   // Assertions.
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (srst_i);
   property p_rst_width; $rose(flash_reset_n_o) |-> low_q >= 12'h07d; endproperty
   a_rst_width: assert property (p_rst_width) else $error("reset pulse too short");
   property p_rst_read; $fell(flash_oe_n_o) |-> hi_q >= 8'h0d; endproperty
   a_rst_read: assert property (p_rst_read) else $error("read too soon after reset");
   property p_no_read; !flash_reset_n_o |-> flash_oe_n_o; endproperty
   a_no_read: assert property (p_no_read) else $error("read while reset low");
   property p_unprot; $rose(unprot_ready_o) |-> hv_q >= 12'h3e8; endproperty
   a_unprot: assert property (p_unprot) else $error("unprotect ready too early");
   property p_read_end; $fell(flash_oe_n_o) |-> !flash_oe_n_o [*8] ##[1:40] flash_oe_n_o; endproperty
   a_read_end: assert property (p_read_end) else $error("read strobe width wrong");
   property p_va; !flash_oe_n_o && mode_q == 2'h0 |-> flash_addr_o == addr_q; endproperty
   a_va: assert property (p_va) else $error("data poll read off address");
   property p_fail; done_o && result_o == fsru_pkg::RES_FAIL |-> rd_q >= ((mode_q == 2'h0) ? 4'h2 : 4'h4); endproperty
   a_fail: assert property (p_fail) else $error("failure without recheck");
   property p_pair; done_o && result_o == fsru_pkg::RES_DONE && mode_q != 2'h0 |-> rd_q >= 4'h2; endproperty
   a_pair: assert property (p_pair) else $error("toggle judged on one read");
   property p_done; done_o |=> !done_o; endproperty
   a_done: assert property (p_done) else $error("done longer than one cycle");
endmodule
bind fsru_host fsru_host_chk u_chk (.ref_clk_i, .srst_i, .poll_start_i, .poll_mode_i, .poll_addr_i, .busy_o,
   .done_o, .result_o, .unprot_ready_o, .flash_addr_o, .flash_oe_n_o, .flash_reset_n_o, .flash_hv_en_o);
`default_nettype wire

// ### sim/fsru_flash_model.sv
// Behavioural model of the flash device status pins.
`default_nettype none
module fsru_flash_model (
   input wire logic [fsru_pkg::ADDR_W-1:0] addr_i,
   input wire logic ce_n_i,
   input wire logic oe_n_i,
   input wire logic reset_n_i,
   input wire logic hv_en_i,
   output logic [fsru_pkg::DATA_W-1:0] dq_o,
   output logic ready_busy_out_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic run = 1'b0, tog = 1'b0, tog2 = 1'b0, tlim = 1'b0, tbit = 1'b0, susp = 1'b0, prot_q = 1'b1;
   logic [fsru_pkg::DATA_W-1:0] word, last = 16'h0000;
   int left = 0;
   wire strobe_n = oe_n_i | ce_n_i;
   wire unlocked = !prot_q || hv_en_i;
   // Status word while busy, array data otherwise; the toggle bit shows at any address.
   always_comb word = run ? {8'h00, ~tbit, tog, tlim, 2'h0, tog2, 2'h0} : {8'h00, tbit, 7'h00};
   // The released bus shows the inverse of the last word.
   assign dq_o = strobe_n ? ~last : word;
   assign ready_busy_out_o = !run;
   // Starts an embedded operation that ends after the given number of extra status reads.
   task automatic begin_op(input int reads, input logic bit_v, input logic overrun, input logic suspend);
      run = 1'b1;
      left = reads;
      tbit = bit_v;
      tlim = overrun;
      susp = suspend;
   endtask
   // The end of either strobe closes a read and advances the toggle bits.
   always @(posedge strobe_n) begin
      last = word;
      if (run) begin
         tog = ~tog;
         if (!susp || addr_i[17:16] == 2'h3)
            tog2 = ~tog2;
         left = left - 1;
         if (left < 0 && !tlim)
            run = 1'b0;
      end
   end
   // Reset aborts the operation and clears the overrun state.
   always @(negedge reset_n_i) begin
      run = 1'b0;
      tlim = 1'b0;
   end
endmodule
`default_nettype wire

// ### sim/testbench.sv
// Self-checking testbench of the flash status, reset and unprotect host controller.
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk_i, srst_i, poll_start_i, expect_bit_i, reset_start_i, unprot_start_i, unprot_end_i;
   logic busy_o, done_o, unprot_ready_o, flash_ce_n_o, flash_oe_n_o, flash_we_n_o, flash_reset_n_o;
   logic flash_hv_en_o, flash_dq_oe_o, ready_busy_out_i, b;
   logic [1:0] poll_mode_i, result_o;
   logic [fsru_pkg::ADDR_W-1:0] poll_addr_i, flash_addr_o;
   logic [fsru_pkg::DATA_W-1:0] last_status_o, flash_dq_o, dev_dq, flash_dq_i;
   int fail_count = 0;
   int comparisons = 0;
   int n;
   // Resolves the shared data bus; the controller only listens.
   assign flash_dq_i = flash_dq_oe_o ? flash_dq_o : dev_dq;
   fsru_host uut (.ref_clk_i, .srst_i, .poll_start_i, .poll_mode_i, .poll_addr_i, .expect_bit_i, .reset_start_i,
      .unprot_start_i, .unprot_end_i, .busy_o, .done_o, .result_o, .unprot_ready_o, .last_status_o, .flash_addr_o,
      .flash_ce_n_o, .flash_oe_n_o, .flash_we_n_o, .flash_reset_n_o, .flash_hv_en_o, .flash_dq_oe_o, .flash_dq_o,
      .flash_dq_i, .ready_busy_out_i);
   fsru_flash_model flash (.addr_i(flash_addr_o), .ce_n_i(flash_ce_n_o), .oe_n_i(flash_oe_n_o),
      .reset_n_i(flash_reset_n_o), .hv_en_i(flash_hv_en_o), .dq_o(dev_dq), .ready_busy_out_o(ready_busy_out_i));
   // Clock at 250 MHz.
   initial begin
      ref_clk_i = 1'b0;
      forever #2 ref_clk_i = ~ref_clk_i;
   end
   // Compares and counts.
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic conclude();
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Expected poll outcome: failure only on overrun.
   function automatic logic [1:0] exp_res(input logic overrun);
      return overrun ? fsru_pkg::RES_FAIL : fsru_pkg::RES_DONE;
   endfunction
   // Pulses one start for a cycle (0 poll, 1 reset, 2 unprotect, 3 end) and counts edges up to done.
   task automatic run_op(input int kind, input logic [1:0] mode, input logic [17:0] addr, input logic bit_v);
      @(posedge ref_clk_i);
      {poll_mode_i, poll_addr_i, expect_bit_i} <= {mode, addr, bit_v};
      {poll_start_i, reset_start_i, unprot_start_i, unprot_end_i} <= 4'h8 >> kind;
      @(posedge ref_clk_i);
      {poll_start_i, reset_start_i, unprot_start_i, unprot_end_i} <= 4'h0;
      n = 1;
      while (done_o !== 1'b1 && n < 8000) begin
         @(posedge ref_clk_i);
         n++;
      end
      if (n >= 8000) begin
         fail_count++;
         $display("ERROR done expected 1 seen timeout");
         conclude();
      end
   endtask
   // Main sequence.
   initial begin
      {srst_i, poll_start_i, expect_bit_i, reset_start_i, unprot_start_i, unprot_end_i} = 6'h20;
      {poll_mode_i, poll_addr_i} = 20'h00000;
      n = $urandom(76);
      repeat (3) @(posedge ref_clk_i);
      srst_i <= 1'b0;
      // Random polls of all three methods, at random addresses, with random busy lengths.
      for (int i = 0; i < 12; i++) begin
         b = 1'($urandom_range(1, 0));
         flash.begin_op($urandom_range(3, 0), b, 1'b0, i[2]);
         run_op(0, 2'(i % 4), 18'($urandom), b);
         check("poll result", result_o, exp_res(1'b0));
         if (i % 4 == 0)
            check("poll data", last_status_o[7], b);
      end
      // A suspended sector keeps toggling for at least two pairs; any other sector is judged on one pair.
      flash.begin_op(2, 1'b0, 1'b0, 1'b1);
      run_op(0, 2'h2, 18'h30000, 1'b0);
      check("suspended sector reads", n >= 208, 1'b1);
      flash.begin_op(2, 1'b0, 1'b0, 1'b1);
      run_op(0, 2'h2, 18'h10000, 1'b0);
      check("other sector reads", n < 208, 1'b1);
      // Overrun in data and toggle polling, each cleared by a reset while busy.
      for (int m = 0; m < 2; m++) begin
         flash.begin_op(0, 1'b1, 1'b1, 1'b0);
         run_op(0, 2'(m), 18'($urandom), 1'b1);
         check("overrun result", result_o, exp_res(1'b1));
         check("overrun status", last_status_o[5], 1'b1);
         run_op(1, 2'h0, 18'h00000, 1'b0);
         check("busy reset time", n >= 5000 && n < 5400, 1'b1);
         check("busy reset result", result_o, fsru_pkg::RES_RESET);
         check("ready after reset", ready_busy_out_i, 1'b1);
      end
      run_op(1, 2'h0, 18'h00000, 1'b0);
      check("idle reset time", n >= 139 && n < 5000, 1'b1);
      run_op(2, 2'h0, 18'h00000, 1'b0);
      check("unprotect result", result_o, fsru_pkg::RES_UNPROT);
      check("unprotect setup", n >= 1000 && n < 1100, 1'b1);
      check("high voltage held", {flash_hv_en_o, unprot_ready_o, flash.unlocked}, 3'h7);
      run_op(3, 2'h0, 18'h00000, 1'b0);
      check("unprotect end", {flash_hv_en_o, unprot_ready_o, flash.unlocked, result_o}, {3'h0, fsru_pkg::RES_RESET});
      // A synchronous reset in the middle of a read returns every pin to idle, and the next poll works.
      flash.begin_op(2, 1'b0, 1'b0, 1'b0);
      @(posedge ref_clk_i);
      poll_start_i <= 1'b1;
      @(posedge ref_clk_i);
      poll_start_i <= 1'b0;
      repeat (10) @(posedge ref_clk_i);
      check("busy mid poll", {busy_o, flash_ce_n_o, flash_oe_n_o, flash_addr_o}, 21'h100000);
      srst_i <= 1'b1;
      @(posedge ref_clk_i);
      srst_i <= 1'b0;
      @(posedge ref_clk_i);
      check("idle pins", {busy_o, done_o, flash_ce_n_o, flash_oe_n_o, flash_we_n_o, flash_reset_n_o}, 6'h0f);
      check("idle bus", {flash_hv_en_o, flash_dq_oe_o, flash_dq_o, result_o}, 20'h00000);
      run_op(0, 2'h0, 18'h00000, 1'b0);
      check("poll after reset", {result_o, last_status_o[7]}, {fsru_pkg::RES_DONE, 1'b0});
      conclude();
   end
endmodule
`default_nettype wire
